/* design/cvs_pkg.sv */
// Purpose: Shared constants and types for the conversion sequencer
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: All offsets are byte addresses of aligned words
package cvs_pkg;

  // ===========================================================
  // Register offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] RES8_OFF = 8'h0C;
  localparam logic [7:0] RES16_OFF = 8'h10;
  localparam logic [7:0] RES32_OFF = 8'h14;
  localparam logic [7:0] CFG_OFF = 8'h18;
  localparam logic [7:0] COH_OFF = 8'h1C;
  localparam logic [7:0] SETUP0_OFF = 8'h20;

  // ===========================================================
  // Field positions
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_HW_SOC = 1;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_POWER_UP = 2;
  localparam int CMD_POWER_DOWN = 3;
  localparam int CMD_SLEEP = 4;
  localparam int CMD_WAKEUP = 5;
  localparam int STAT_EOC = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_PEND = 2;
  localparam int STAT_POWER = 3;
  localparam int STAT_SLEEP = 4;
  localparam int SETUP_MODE_LSB = 0;
  localparam int SETUP_GAIN_LSB = 2;

  // ===========================================================
  // Reset values and timing
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] COH_RST = 2'h0;
  localparam logic [3:0] SETUP_RST = 4'h0;
  localparam int CONV_NS = 1000;
  localparam int CLK_NS = 40;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;

  // ===========================================================
  // Modes and gains
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_MULTI = 2'h1,
    MODE_CONT = 2'h2,
    MODE_TURBO = 2'h3
  } cvs_mode_e;

  typedef enum logic [1:0] {
    buffer_gain_one = 2'h0,
    buffer_gain_two = 2'h1,
    buffer_gain_four = 2'h2,
    buffer_gain_eight = 2'h3
  } cvs_gain_e;

  // One stored setup: mode and gain
  typedef struct packed {
    cvs_gain_e gain;
    cvs_mode_e mode;
  } cvs_setup_s;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_CONV = 4'b0100,
    ST_SLEEP = 4'b1000
  } cvs_state_e;

endpackage : cvs_pkg

/* design/cvs_top.sv */
// Purpose: Start/stop sequencing, status and results of a converter
// Assumes: Modulator delivers a sample at conv_done_i; AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

module cvs_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter side
  input wire logic hw_soc_i,
  input wire logic conv_done_i,
  input wire logic [31:0] conv_data_i,
  input wire logic dma_read_i,
  output logic conv_run_o,
  output logic conv_abort_o,
  output logic power_on_o,
  output logic [1:0] buf_gain_o,
  output logic [1:0] conv_mode_o,
  output logic eoc_o,
  output logic irq_o
);

  // ===========================================================
  // Declarations
  cvs_pkg::cvs_state_e state;
  cvs_pkg::cvs_setup_s setups [4];
  cvs_pkg::cvs_setup_s active;
  logic [1:0] cfg_sel;
  logic [1:0] coh_sel;
  logic irq_en, hw_en;
  logic pending, repeat_on, eoc, irq_pend, asleep;
  logic [31:0] result;
  logic [7:0] aw_addr, ar_addr;
  logic aw_have, w_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic soc_s1, soc_s2, soc_s3;
  logic wr_fire, rd_fire, res_read, cmd_wr;
  logic start_req, stop_req, done_ok;
  logic [31:0] cmd_bits, rd_word;

  // Byte-lane merge of a register with write data
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Address is one of the result views
  function automatic logic is_result(input logic [7:0] a);
    return (a == cvs_pkg::RES8_OFF) || (a == cvs_pkg::RES16_OFF) ||
           (a == cvs_pkg::RES32_OFF);
  endfunction

  // ===========================================================
  // AXI4-Lite write channel: address and data in either order
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready only while the slot is empty; response is always OKAY
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready = !w_have && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;
  assign wr_fire = aw_have && w_have && !s_axi_bvalid;
  assign cmd_wr = wr_fire && (aw_addr == cvs_pkg::CMD_OFF);
  assign cmd_bits = cmd_wr ? (w_data & {{24{1'b0}}, {8{w_strb[0]}}})
                           : 32'h0000_0000;

  // ===========================================================
  // Control, coherency and stored setup registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_en <= cvs_pkg::CTRL_RST[cvs_pkg::CTRL_IRQ_EN];
      hw_en <= cvs_pkg::CTRL_RST[cvs_pkg::CTRL_HW_SOC];
      coh_sel <= cvs_pkg::COH_RST;
      for (int i = 0; i < 4; i++) begin
        setups[i] <= cvs_pkg::cvs_setup_s'(cvs_pkg::SETUP_RST);
      end
    end else if (wr_fire) begin
      case (aw_addr)
        cvs_pkg::CTRL_OFF: begin
          if (w_strb[0]) begin
            irq_en <= w_data[cvs_pkg::CTRL_IRQ_EN];
            hw_en <= w_data[cvs_pkg::CTRL_HW_SOC];
          end
        end
        cvs_pkg::COH_OFF: begin
          if (w_strb[0]) begin
            coh_sel <= w_data[1:0];
          end
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (aw_addr == cvs_pkg::SETUP0_OFF + 8'(4 * i) && w_strb[0])
            begin
              setups[i] <= cvs_pkg::cvs_setup_s'(w_data[3:0]);
            end
          end
        end
      endcase
    end
  end

  // Setup selection writes are dropped while a conversion runs
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_sel <= 2'h0;
    end else if (wr_fire && aw_addr == cvs_pkg::CFG_OFF && w_strb[0] &&
                 state != cvs_pkg::ST_CONV) begin
      cfg_sel <= w_data[1:0];
    end
  end

  // Active setup latched only between conversions
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      active <= cvs_pkg::cvs_setup_s'(cvs_pkg::SETUP_RST);
    end else if (state != cvs_pkg::ST_CONV && state != cvs_pkg::ST_SLEEP)
    begin
      active <= setups[cfg_sel];
    end
  end

  // ===========================================================
  // Hardware start: two-flop synchroniser then edge detect
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      soc_s1 <= 1'b0;
      soc_s2 <= 1'b0;
      soc_s3 <= 1'b0;
    end else begin
      soc_s1 <= hw_soc_i;
      soc_s2 <= soc_s1;
      soc_s3 <= soc_s2;
    end
  end

  // Rising edge only counts when enabled and not converting
  assign start_req = cmd_bits[cvs_pkg::CMD_START] ||
      (hw_en && soc_s2 && !soc_s3 && state != cvs_pkg::ST_CONV);
  assign stop_req = cmd_bits[cvs_pkg::CMD_STOP];
  // A sample that meets any aborting command is dropped with its run
  assign done_ok = state == cvs_pkg::ST_CONV && conv_done_i && !stop_req &&
      !cmd_bits[cvs_pkg::CMD_POWER_DOWN] &&
      !cmd_bits[cvs_pkg::CMD_SLEEP];

  // ===========================================================
  // Sequencer state machine
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= cvs_pkg::ST_OFF;
      pending <= 1'b0;
      repeat_on <= 1'b0;
      conv_abort_o <= 1'b0;
    end else begin
      conv_abort_o <= 1'b0;
      case (state)
        cvs_pkg::ST_OFF: begin
          if (cmd_bits[cvs_pkg::CMD_POWER_UP]) begin
            state <= cvs_pkg::ST_IDLE;
          end
        end
        cvs_pkg::ST_IDLE: begin
          if (cmd_bits[cvs_pkg::CMD_POWER_DOWN]) begin
            state <= cvs_pkg::ST_OFF;
          end else if (cmd_bits[cvs_pkg::CMD_SLEEP]) begin
            state <= cvs_pkg::ST_SLEEP;
          end else if (start_req && !stop_req) begin
            state <= cvs_pkg::ST_CONV;
            repeat_on <= active.mode != cvs_pkg::MODE_SINGLE;
          end
        end
        cvs_pkg::ST_CONV: begin
          if (stop_req || cmd_bits[cvs_pkg::CMD_POWER_DOWN] ||
              cmd_bits[cvs_pkg::CMD_SLEEP]) begin
            // Abort drops the partial sample and any queued start
            conv_abort_o <= 1'b1;
            pending <= 1'b0;
            repeat_on <= 1'b0;
            state <= cmd_bits[cvs_pkg::CMD_POWER_DOWN] ? cvs_pkg::ST_OFF
                   : cmd_bits[cvs_pkg::CMD_SLEEP] ? cvs_pkg::ST_SLEEP
                   : cvs_pkg::ST_IDLE;
          end else if (conv_done_i) begin
            if (repeat_on || pending || start_req) begin
              pending <= 1'b0;
            end else begin
              state <= cvs_pkg::ST_IDLE;
            end
          end else if (cmd_bits[cvs_pkg::CMD_START]) begin
            pending <= 1'b1;
          end
        end
        cvs_pkg::ST_SLEEP: begin
          if (cmd_bits[cvs_pkg::CMD_WAKEUP]) begin
            state <= cvs_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= cvs_pkg::ST_OFF;
        end
      endcase
    end
  end

  // ===========================================================
  // Result capture, end-of-conversion flag and interrupt
  assign res_read = rd_fire && is_result(ar_addr) &&
      (ar_addr == cvs_pkg::RES32_OFF || coh_sel == 2'h0);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      result <= 32'h0000_0000;
      eoc <= 1'b0;
      irq_pend <= 1'b0;
    end else begin
      if (done_ok) begin
        result <= conv_data_i;
      end
      // New completion wins over a same-cycle clear
      if (done_ok) begin
        eoc <= 1'b1;
      end else if (res_read || dma_read_i ||
                   (start_req && state != cvs_pkg::ST_CONV)) begin
        eoc <= 1'b0;
      end
      if (done_ok && irq_en) begin
        irq_pend <= 1'b1;
      end else if (res_read || dma_read_i || !irq_en) begin
        irq_pend <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Registered outputs to the converter
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      conv_run_o <= 1'b0;
      power_on_o <= 1'b0;
      buf_gain_o <= 2'h0;
      conv_mode_o <= 2'h0;
      eoc_o <= 1'b0;
      irq_o <= 1'b0;
      asleep <= 1'b0;
    end else begin
      conv_run_o <= state == cvs_pkg::ST_CONV;
      power_on_o <= state == cvs_pkg::ST_IDLE || state == cvs_pkg::ST_CONV;
      buf_gain_o <= active.gain;
      conv_mode_o <= active.mode;
      eoc_o <= eoc;
      irq_o <= irq_pend;
      asleep <= state == cvs_pkg::ST_SLEEP;
    end
  end

  // ===========================================================
  // AXI4-Lite read channel, one cycle after address accept
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign ar_addr = s_axi_araddr;
  assign s_axi_rresp = 2'b00;

  // Read decode; result views are sign extended
  always_comb begin
    rd_word = 32'h0000_0000;
    case (ar_addr)
      cvs_pkg::CTRL_OFF: rd_word = {30'h0000_0000, hw_en, irq_en};
      cvs_pkg::STAT_OFF: rd_word = {27'h0000_0000, asleep, power_on_o,
                                    pending, conv_run_o, eoc};
      cvs_pkg::RES8_OFF: rd_word = {{24{result[7]}}, result[7:0]};
      cvs_pkg::RES16_OFF: rd_word = {{16{result[15]}}, result[15:0]};
      cvs_pkg::RES32_OFF: rd_word = result;
      cvs_pkg::CFG_OFF: rd_word = {30'h0000_0000, cfg_sel};
      cvs_pkg::COH_OFF: rd_word = {30'h0000_0000, coh_sel};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (ar_addr == cvs_pkg::SETUP0_OFF + 8'(4 * i)) begin
            rd_word = {28'h000_0000, setups[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // cvs_top

`default_nettype wire

/* tb/cvs_properties.sv */
// Purpose: Temporal checks on the sequencer's converter-side outputs
// Assumes: Bound to cvs_top; one clock, sync active-high reset
// Notes: Stimulus never stops a run in the cycle of a sample
`timescale 1ns/1ps
`default_nettype none

module cvs_properties (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Converter side
  input wire logic conv_done_i,
  input wire logic dma_read_i,
  input wire logic conv_run_o,
  input wire logic conv_abort_o,
  input wire logic power_on_o,
  input wire logic [1:0] buf_gain_o,
  input wire logic [1:0] conv_mode_o,
  input wire logic eoc_o,
  input wire logic irq_o
);
  // ==========================================================
  // Sequencing checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // The flag passes two registers after the sample is taken
  a_done_sets_flag: assert property (
    conv_run_o && conv_done_i |-> ##2 eoc_o)
    else $error("sample did not raise the end flag");
  a_repeat_keeps_running: assert property (
    conv_run_o && conv_done_i &&
    conv_mode_o != cvs_pkg::MODE_SINGLE |=> conv_run_o)
    else $error("repeating mode stopped after a sample");
  // Abort and run flag are registered from the same state
  a_abort_needs_run: assert property (
    $rose(conv_abort_o) |-> conv_run_o)
    else $error("abort without a running conversion");
  a_abort_no_result: assert property (
    conv_abort_o |=> $stable(eoc_o))
    else $error("aborted conversion changed the end flag");
  a_dma_clears_flag: assert property (
    dma_read_i && !conv_done_i |-> ##2 !eoc_o && !irq_o)
    else $error("dma read left flag or interrupt set");
  // A new start may drop the flag while the interrupt stays raised
  a_irq_has_flag: assert property ($rose(irq_o) |-> eoc_o)
    else $error("interrupt rose without end flag");
  a_off_no_run: assert property (!power_on_o |-> !conv_run_o)
    else $error("conversion while powered down");
  a_setup_steady: assert property (
    conv_run_o && $past(conv_run_o) |->
    $stable(buf_gain_o) && $stable(conv_mode_o))
    else $error("setup changed during a conversion");

  // Main scenarios reached
  c_single_done: cover property (conv_run_o && conv_done_i &&
    conv_mode_o == cvs_pkg::MODE_SINGLE);
  c_abort: cover property (conv_abort_o);
  c_irq_cleared: cover property (irq_o ##1 !irq_o);
endmodule // cvs_properties

`default_nettype wire

/* tb/cvs_top_bench.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Bench acts as AXI4-Lite master and as the modulator
// Notes: Samples are pulsed by hand, so run length is the bench's
`timescale 1ns/1ps
`default_nettype none

module cvs_top_bench;
  // ==========================================================
  // Signals
  logic clock_i, sys_rst_i, hw_soc_i, conv_done_i, dma_read_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, conv_data_i, rv;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, conv_run_o, conv_abort_o;
  logic power_on_o, eoc_o, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, buf_gain_o, conv_mode_o;
  int num_errors = 0;
  int comparisons = 0;

  cvs_top u_dut (.clock_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_soc_i, .conv_done_i,
    .conv_data_i, .dma_read_i, .conv_run_o, .conv_abort_o, .power_on_o,
    .buf_gain_o, .conv_mode_o, .eoc_o, .irq_o);

  // ==========================================================
  // Clock and watchdog (whole script needs about 300 cycles)
  initial begin
    clock_i = 1'h0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    #400_000;
    num_errors++;
    end_of_test();
  end

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, released as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    s_axi_rready <= 1'h0;
    chk(rv & m, e);
  endtask
  task automatic cmd(input int b);
    wr(cvs_pkg::CMD_OFF, 32'h0000_0001 << b);
  endtask
  // Order: power, run, end flag, interrupt
  task automatic pins(input logic [3:0] e);
    repeat (2) @(posedge clock_i);
    chk({28'h0, power_on_o, conv_run_o, eoc_o, irq_o}, {28'h0, e});
  endtask
  task automatic setup(input logic [3:0] e);
    repeat (2) @(posedge clock_i);
    chk({28'h0, buf_gain_o, conv_mode_o}, {28'h0, e});
  endtask
  // Sample data is scrambled once its strobe has gone
  task automatic sample(input logic [31:0] d);
    @(posedge clock_i);
    conv_done_i <= 1'h1;
    conv_data_i <= d;
    @(posedge clock_i);
    conv_done_i <= 1'h0;
    conv_data_i <= ~d;
  endtask
  task automatic go();
    cmd(cvs_pkg::CMD_START);
    while (conv_run_o !== 1'h1) @(posedge clock_i);
  endtask
  task automatic pulse_dma();
    @(posedge clock_i);
    dma_read_i <= 1'h1;
    @(posedge clock_i);
    dma_read_i <= 1'h0;
  endtask

  // ==========================================================
  // Script
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_data_i} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, hw_soc_i, conv_done_i, dma_read_i} = '0;
    s_axi_wstrb = 4'hF;
    sys_rst_i = 1'h1;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    pins(4'h0);
    rc(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    cmd(cvs_pkg::CMD_POWER_UP);
    pins(4'h8);
    rc(cvs_pkg::STAT_OFF, 32'hFFFF_FFFF, 32'h0000_0008);
    setup(4'h0);
    for (int g = 0; g < 4; g++) begin
      wr(cvs_pkg::SETUP0_OFF, 32'(g << 2));
      setup(4'(g << 2));
    end
    // Single mode with a start queued behind the running one
    wr(cvs_pkg::CTRL_OFF, 32'h0000_0001);
    go();
    cmd(cvs_pkg::CMD_START);
    rc(cvs_pkg::STAT_OFF, 32'h0000_0006, 32'h0000_0006);
    sample(32'h0000_0011);
    pins(4'hF);
    sample(32'h0001_8085);
    pins(4'hB);
    pins(4'hB);
    rc(cvs_pkg::RES8_OFF, 32'hFFFF_FFFF, 32'hFFFF_FF85);
    pins(4'h8);
    rc(cvs_pkg::RES16_OFF, 32'hFFFF_FFFF, 32'hFFFF_8085);
    rc(cvs_pkg::RES32_OFF, 32'hFFFF_FFFF, 32'h0001_8085);
    // Coherent mode: of the result views only the wide one releases the flag
    wr(cvs_pkg::COH_OFF, 32'h0000_0001);
    go();
    sample(32'h0000_0007);
    pins(4'hB);
    rc(cvs_pkg::RES8_OFF, 32'hFFFF_FFFF, 32'h0000_0007);
    pins(4'hB);
    rc(cvs_pkg::RES32_OFF, 32'hFFFF_FFFF, 32'h0000_0007);
    pins(4'h8);
    go();
    sample(32'h0000_0009);
    wr(cvs_pkg::CTRL_OFF, 32'h0000_0000);
    pins(4'hA);
    pulse_dma();
    pins(4'h8);
    go();
    sample(32'h0000_0003);
    pins(4'hA);
    // Repeating mode, then stop with a start pending
    wr(cvs_pkg::SETUP0_OFF, 32'h0000_0001);
    go();
    for (int i = 0; i < 3; i++) sample(32'(i + 32'h20));
    pins(4'hE);
    cmd(cvs_pkg::CMD_START);
    cmd(cvs_pkg::CMD_STOP);
    rc(cvs_pkg::STAT_OFF, 32'h0000_0006, 32'h0000_0000);
    // Stop in mid-conversion drops the late sample
    pulse_dma();
    go();
    cmd(cvs_pkg::CMD_STOP);
    // Abort pulse launched with the response still stands at this edge
    chk(32'(conv_abort_o), 32'h0000_0001);
    sample(32'h0000_0055);
    pins(4'h8);
    rc(cvs_pkg::RES32_OFF, 32'hFFFF_FFFF, 32'h0000_0022);
    // Hardware start; a second edge while busy is ignored
    wr(cvs_pkg::SETUP0_OFF, 32'h0000_0000);
    wr(cvs_pkg::CTRL_OFF, 32'h0000_0002);
    hw_soc_i <= 1'h1;
    // Two sync flops, edge detect, state, then the run register
    repeat (5) @(posedge clock_i);
    chk(32'(conv_run_o), 32'h0000_0001);
    hw_soc_i <= 1'h0;
    repeat (4) @(posedge clock_i);
    hw_soc_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    hw_soc_i <= 1'h0;
    sample(32'h0000_0033);
    repeat (4) @(posedge clock_i);
    pins(4'hA);
    // Setup select is honoured only between conversions
    wr(cvs_pkg::CTRL_OFF, 32'h0000_0000);
    wr(8'h24, 32'h0000_000E);
    wr(cvs_pkg::CFG_OFF, 32'h0000_0001);
    setup(4'hE);
    go();
    wr(cvs_pkg::CFG_OFF, 32'h0000_0000);
    setup(4'hE);
    cmd(cvs_pkg::CMD_STOP);
    // Sleep keeps the active setup through wakeup
    cmd(cvs_pkg::CMD_SLEEP);
    rc(cvs_pkg::STAT_OFF, 32'h0000_0012, 32'h0000_0010);
    cmd(cvs_pkg::CMD_WAKEUP);
    setup(4'hE);
    rc(cvs_pkg::STAT_OFF, 32'h0000_0018, 32'h0000_0008);
    cmd(cvs_pkg::CMD_POWER_DOWN);
    pins(4'h0);
    end_of_test();
  end
endmodule // cvs_top_bench

bind cvs_top cvs_properties u_props (.clock_i, .sys_rst_i, .conv_done_i,
  .dma_read_i, .conv_run_o, .conv_abort_o, .power_on_o, .buf_gain_o,
  .conv_mode_o, .eoc_o, .irq_o);

`default_nettype wire
